// *** src/sdw_defs.svh ***
`ifndef SDW_DEFS_SVH
`define SDW_DEFS_SVH

// ---------------------------------------------------------------------------
// Register word indexes (byte address is four times the index)
// ---------------------------------------------------------------------------
`define SDW_IDX_CTRL 6'h28
`define SDW_IDX_COARSE 6'h29
`define SDW_IDX_FINE 6'h2a
`define SDW_IDX_STATUS 6'h2b
`define SDW_IDX_POS_LOW 6'h2c
`define SDW_IDX_POS_MID 6'h2d
`define SDW_IDX_POS_HIGH 6'h2e
`define SDW_IDX_CAPSEL 6'h2f

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define SDW_CTRL_INVERT 0
`define SDW_CTRL_RAMP_EN 1
`define SDW_CTRL_RAMP_FAST 2
`define SDW_CTRL_STEP_FINE 3
`define SDW_CTRL_SINGLE_CH 4
`define SDW_CTRL_WIDTH 5
`define SDW_CTRL_RESET 5'h00

// ---------------------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------------------
`define SDW_STAT_VALID 0
`define SDW_STAT_BUSY 1
`define SDW_STAT_DIR_UP 2
`define SDW_STAT_ACTIVE_LSB 8

// ---------------------------------------------------------------------------
// Codes, widths and reset values
// ---------------------------------------------------------------------------
`define SDW_CODE_WIDTH 8
`define SDW_CODE_RESET 8'h00
`define SDW_SEL_WIDTH 4
`define SDW_SEL_RESET 4'h0
`define SDW_POS_COUNT 24
`define SDW_POS_EDGE_MIN 2'h3

// ---------------------------------------------------------------------------
// Ramp timing in device clock cycles
// ---------------------------------------------------------------------------
`define SDW_RAMP_WINDOW 256
`define SDW_RAMP_SLOW_STEPS 1
`define SDW_RAMP_FAST_STEPS 4

`endif

// *** src/sdw_pkg.sv ***
package sdw_pkg;

  // -------------------------------------------------------------------------
  // Ramp engine states
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SDW_RAMP_IDLE = 2'b01,
    SDW_RAMP_RUN = 2'b10
  } sdw_ramp_state_t;

  typedef logic [7:0] sdw_code_t;

endpackage

// *** src/sdw_pos_detect.sv ***
`include "sdw_defs.svh"

module sdw_pos_detect #(
  parameter int TAPS = `SDW_POS_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [TAPS-1:0] sysref_tap_i,
  input wire logic step_fine_i,
  input wire logic [`SDW_SEL_WIDTH-1:0] sel_i,
  output logic [TAPS-1:0] flags_o,
  output logic valid_o,
  output logic capture_o
);

  logic [TAPS-1:0] meta_r;
  logic [TAPS-1:0] sync_r;
  logic ref_prev_r;
  logic step_prev_r;
  logic [1:0] edge_cnt_r;
  logic [TAPS-1:0] risk;
  logic rise;

  // ---------------------------------------------------------------------------
  // Tap synchroniser
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= sysref_tap_i;
      sync_r <= meta_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Risk map
  // ---------------------------------------------------------------------------
  // Tap 0 is the least delayed copy, so its rising edge marks each SYSREF rising edge.
  assign rise = sync_r[0] & ~ref_prev_r;

  assign risk[0] = 1'b1;
  assign risk[TAPS-1] = 1'b1;
  genvar g;
  generate
    for (g = 1; g < TAPS - 1; g++)
    begin : g_risk
      assign risk[g] = (sync_r[g] ^ sync_r[g-1]) | (sync_r[g] ^ sync_r[g+1]);
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_prev_r <= 1'b0;
      step_prev_r <= 1'b0;
      edge_cnt_r <= 2'h0;
      flags_o <= '1;
      valid_o <= 1'b0;
    end
    else
    begin
      ref_prev_r <= sync_r[0];
      step_prev_r <= step_fine_i;
      // A new step size moves every tap, so the old map no longer applies.
      if (step_fine_i != step_prev_r)
      begin
        edge_cnt_r <= 2'h0;
        valid_o <= 1'b0;
        flags_o <= '1;
      end
      else if (rise)
      begin
        if (edge_cnt_r != `SDW_POS_EDGE_MIN)
          edge_cnt_r <= edge_cnt_r + 2'h1;
        // The map stays all ones until the third edge, so software never reads a partial map.
        if (edge_cnt_r >= (`SDW_POS_EDGE_MIN - 2'h1))
        begin
          flags_o <= risk;
          valid_o <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      capture_o <= 1'b0;
    else
      capture_o <= sync_r[sel_i];
  end

endmodule

// *** src/sdw_delay_ctrl.sv ***
// Our own choice: the Wishbone interface to the registers.
`include "sdw_defs.svh"

module sdw_delay_ctrl #(
  parameter int TAPS = `SDW_POS_COUNT,
  parameter int RAMP_WINDOW = `SDW_RAMP_WINDOW
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [TAPS-1:0] sysref_tap_i,
  output logic clock_invert_half_period_o,
  output logic [`SDW_CODE_WIDTH-1:0] coarse_delay_code_o,
  output logic [`SDW_CODE_WIDTH-1:0] fine_delay_code_o,
  output logic position_step_fine_o,
  output logic [`SDW_SEL_WIDTH-1:0] sysref_sel_o,
  output logic dual_edge_sample_o,
  output logic sysref_capture_o,
  output logic ramp_busy_o
);

  localparam int SLOW_PERIOD = RAMP_WINDOW / `SDW_RAMP_SLOW_STEPS;
  localparam int FAST_PERIOD = RAMP_WINDOW / `SDW_RAMP_FAST_STEPS;
  localparam int CNT_W = $clog2(SLOW_PERIOD);
  localparam int FAST_W = $clog2(FAST_PERIOD);

  logic [`SDW_CTRL_WIDTH-1:0] ctrl_r;
  sdw_pkg::sdw_code_t target_r;
  sdw_pkg::sdw_code_t fine_r;
  logic [`SDW_SEL_WIDTH-1:0] capsel_r;
  sdw_pkg::sdw_ramp_state_t ramp_r;
  sdw_pkg::sdw_ramp_state_t ramp_nxt;
  logic [CNT_W-1:0] tick_cnt_r;
  logic tick;
  logic req;
  logic wr;
  logic coarse_wr;
  logic [TAPS-1:0] flags;
  logic flags_valid;
  logic capture;
  logic [31:0] rd_data;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    hit = (adr[7:2] == idx);
  endfunction

  // A request is answered one cycle after it is seen. The write lands at the edge that
  // samples ack high, where the master still holds address and data.
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign coarse_wr = wr & hit(wb_adr_i, `SDW_IDX_COARSE);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  // ---------------------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------------------
  // independent controls
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_r <= `SDW_CTRL_RESET;
    else if (wr && hit(wb_adr_i, `SDW_IDX_CTRL))
      ctrl_r <= wb_dat_i[`SDW_CTRL_WIDTH-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      target_r <= `SDW_CODE_RESET;
    else if (coarse_wr)
      target_r <= wb_dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fine_r <= `SDW_CODE_RESET;
    else if (wr && hit(wb_adr_i, `SDW_IDX_FINE))
      fine_r <= wb_dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      capsel_r <= `SDW_SEL_RESET;
    else if (wr && hit(wb_adr_i, `SDW_IDX_CAPSEL))
      capsel_r <= wb_dat_i[`SDW_SEL_WIDTH-1:0];
  end

  // ---------------------------------------------------------------------------
  // Ramp step timer
  // ---------------------------------------------------------------------------
  // one or four steps
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ramp_r == sdw_pkg::SDW_RAMP_IDLE || coarse_wr)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 1'b1;
  end

  always_comb
  begin
    if (ctrl_r[`SDW_CTRL_RAMP_FAST])
      tick = (tick_cnt_r[FAST_W-1:0] == FAST_W'(FAST_PERIOD - 1));
    else
      tick = (tick_cnt_r == CNT_W'(SLOW_PERIOD - 1));
  end

  // ---------------------------------------------------------------------------
  // Ramp engine
  // ---------------------------------------------------------------------------
  always_comb
  begin
    ramp_nxt = ramp_r;
    case (ramp_r)
      sdw_pkg::SDW_RAMP_IDLE:
      begin
        if (coarse_wr && ctrl_r[`SDW_CTRL_RAMP_EN] && wb_dat_i[7:0] != coarse_delay_code_o)
          ramp_nxt = sdw_pkg::SDW_RAMP_RUN;
      end
      sdw_pkg::SDW_RAMP_RUN:
      begin
        if (!ctrl_r[`SDW_CTRL_RAMP_EN])
          ramp_nxt = sdw_pkg::SDW_RAMP_IDLE;
        else if (coarse_wr)
          ramp_nxt = (wb_dat_i[7:0] == coarse_delay_code_o) ? sdw_pkg::SDW_RAMP_IDLE
                                                             : sdw_pkg::SDW_RAMP_RUN;
        // Widened so that a ramp toward either end of the code range does not stop on wrap.
        else if (tick && ({1'b0, coarse_delay_code_o} == {1'b0, target_r} + 9'h001 ||
                          {1'b0, coarse_delay_code_o} + 9'h001 == {1'b0, target_r}))
          ramp_nxt = sdw_pkg::SDW_RAMP_IDLE;
      end
      default:
        ramp_nxt = sdw_pkg::SDW_RAMP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ramp_r <= sdw_pkg::SDW_RAMP_IDLE;
    else
      ramp_r <= ramp_nxt;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ramp_busy_o <= 1'b0;
    else
      ramp_busy_o <= (ramp_nxt == sdw_pkg::SDW_RAMP_RUN);
  end

  // ---------------------------------------------------------------------------
  // Active coarse code
  // ---------------------------------------------------------------------------
  // gradual or direct
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      coarse_delay_code_o <= `SDW_CODE_RESET;
    else if (!ctrl_r[`SDW_CTRL_RAMP_EN])
      coarse_delay_code_o <= target_r;
    else if (ramp_r == sdw_pkg::SDW_RAMP_RUN && tick && !coarse_wr)
    begin
      if (coarse_delay_code_o < target_r)
        coarse_delay_code_o <= coarse_delay_code_o + 8'h01;
      else if (coarse_delay_code_o > target_r)
        coarse_delay_code_o <= coarse_delay_code_o - 8'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Analog control outputs
  // ---------------------------------------------------------------------------
  // Codes feed the analog clock path; every internal clock, the serial output and
  // SYSREF capture follow from that one delayed clock.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clock_invert_half_period_o <= 1'b0;
      fine_delay_code_o <= `SDW_CODE_RESET;
      position_step_fine_o <= 1'b0;
      sysref_sel_o <= `SDW_SEL_RESET;
      dual_edge_sample_o <= 1'b0;
    end
    else
    begin
      clock_invert_half_period_o <= ctrl_r[`SDW_CTRL_INVERT];
      fine_delay_code_o <= fine_r;
      position_step_fine_o <= ctrl_r[`SDW_CTRL_STEP_FINE];
      sysref_sel_o <= capsel_r;
      dual_edge_sample_o <= ctrl_r[`SDW_CTRL_SINGLE_CH];
    end
  end

  // ---------------------------------------------------------------------------
  // Position detector
  // ---------------------------------------------------------------------------
  sdw_pos_detect #(
    .TAPS(TAPS)
  ) i_sdw_pos_detect (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sysref_tap_i(sysref_tap_i),
    .step_fine_i(position_step_fine_o),
    .sel_i(sysref_sel_o),
    .flags_o(flags),
    .valid_o(flags_valid),
    .capture_o(capture)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sysref_capture_o <= 1'b0;
    else
      sysref_capture_o <= capture;
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit(wb_adr_i, `SDW_IDX_CTRL))
      rd_data[`SDW_CTRL_WIDTH-1:0] = ctrl_r;
    else if (hit(wb_adr_i, `SDW_IDX_COARSE))
      rd_data[7:0] = target_r;
    else if (hit(wb_adr_i, `SDW_IDX_FINE))
      rd_data[7:0] = fine_r;
    else if (hit(wb_adr_i, `SDW_IDX_STATUS))
    begin
      rd_data[`SDW_STAT_VALID] = flags_valid;
      rd_data[`SDW_STAT_BUSY] = ramp_busy_o;
      rd_data[`SDW_STAT_DIR_UP] = (coarse_delay_code_o < target_r);
      rd_data[`SDW_STAT_ACTIVE_LSB +: 8] = coarse_delay_code_o;
    end
    else if (hit(wb_adr_i, `SDW_IDX_POS_LOW))
      rd_data[7:0] = flags[7:0];
    else if (hit(wb_adr_i, `SDW_IDX_POS_MID))
      rd_data[7:0] = flags[15:8];
    else if (hit(wb_adr_i, `SDW_IDX_POS_HIGH))
      rd_data[7:0] = flags[23:16];
    else if (hit(wb_adr_i, `SDW_IDX_CAPSEL))
      rd_data[`SDW_SEL_WIDTH-1:0] = capsel_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req)
      wb_dat_o <= rd_data;
  end

endmodule

// *** test/sdw_sysref_gen.sv ***
module sdw_sysref_gen #(
  parameter int TAPS = 24,
  parameter int HALF = 20
) (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [4:0] pos_i,
  output logic [TAPS-1:0] sysref_tap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic lvl = 1'b0;
  // ---------------------------------------------------------------------
  // Periodic SYSREF seen through the delayed detector clocks
  // ---------------------------------------------------------------------
  // continuous rising edges
  always @(posedge clk_i)
  begin
    cnt <= (run_i && cnt < HALF - 1) ? cnt + 1 : 0;
    if (!run_i)
      lvl <= 1'b0;
    else if (cnt == HALF - 1)
      lvl <= ~lvl;
  end
  // Taps below the edge position see the pulse, so tap 0 rises whenever pos_i is above zero.
  assign sysref_tap_o = lvl ? (TAPS'(1) << pos_i) - TAPS'(1) : '0;
endmodule

// *** test/sdw_delay_ctrl_monitor.sv ***
module sdw_delay_ctrl_mon #(
  parameter int TAPS = 24,
  parameter int RAMP_WINDOW = 256
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [TAPS-1:0] sysref_tap_i,
  input wire logic clock_invert_half_period_o,
  input wire logic [7:0] coarse_delay_code_o,
  input wire logic [7:0] fine_delay_code_o,
  input wire logic position_step_fine_o,
  input wire logic [3:0] sysref_sel_o,
  input wire logic dual_edge_sample_o,
  input wire logic sysref_capture_o,
  input wire logic ramp_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  localparam int FAST = RAMP_WINDOW / 4;
  logic [15:0] gap_r;
  logic [2:0] up_r;
  // ---------------------------------------------------------------------
  // Helpers and sequences
  // ---------------------------------------------------------------------
  // The gap counter gives the spacing of coarse steps without long repetitions.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gap_r <= 16'h0;
      up_r <= 3'h0;
    end
    else
    begin
      gap_r <= $changed(coarse_delay_code_o) ? 16'h0 : gap_r + 16'(gap_r != 16'hffff);
      up_r <= up_r + 3'(up_r != 3'h7);
    end
  end
  sequence s_wr(a);
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
  endsequence
  sequence s_rd(a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_CTRL_APPLY: assert property (s_wr(8'ha0) |-> ##2
    {dual_edge_sample_o, position_step_fine_o, clock_invert_half_period_o} ==
    {$past(wb_dat_i[4], 2), $past(wb_dat_i[3], 2), $past(wb_dat_i[0], 2)})
    else $error("control outputs do not follow write");
  AST_FINE_APPLY: assert property (s_wr(8'ha8) |-> ##2
    fine_delay_code_o == $past(wb_dat_i[7:0], 2))
    else $error("fine code does not follow write");
  AST_SEL_APPLY: assert property (s_wr(8'hbc) |-> ##2
    sysref_sel_o == $past(wb_dat_i[3:0], 2))
    else $error("capture select does not follow write");
  AST_RAMP_UNIT: assert property (ramp_busy_o && $past(ramp_busy_o) |->
    coarse_delay_code_o == $past(coarse_delay_code_o) ||
    coarse_delay_code_o == $past(coarse_delay_code_o) + 8'h1 ||
    coarse_delay_code_o == $past(coarse_delay_code_o) - 8'h1)
    else $error("ramp moved more than one step");
  AST_RAMP_RATE: assert property (ramp_busy_o && $past(ramp_busy_o) &&
    $changed(coarse_delay_code_o) |-> gap_r >= 16'(FAST - 1))
    else $error("ramp steps too close");
  AST_CAPTURE_TAP: assert property (up_r == 3'h7 &&
    $past(sysref_sel_o, 4) == sysref_sel_o |->
    sysref_capture_o == $past(sysref_tap_i[sysref_sel_o], 3) ||
    sysref_capture_o == $past(sysref_tap_i[sysref_sel_o], 4))
    else $error("capture not from selected tap");
  AST_FLAG_ENDS: assert property (s_rd(8'hb0) |-> wb_dat_o[0])
    else $error("end flag reads zero");
endmodule

bind sdw_delay_ctrl sdw_delay_ctrl_mon #(.TAPS(TAPS), .RAMP_WINDOW(RAMP_WINDOW))
  i_sdw_delay_ctrl_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sysref_tap_i, .clock_invert_half_period_o,
  .coarse_delay_code_o, .fine_delay_code_o, .position_step_fine_o, .sysref_sel_o,
  .dual_edge_sample_o, .sysref_capture_o, .ramp_busy_o);

// *** test/tb_sdw_delay_ctrl.sv ***
module tb_sdw_delay_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RW = 16;
  typedef struct {string n; logic [31:0] v; logic [31:0] m;} sdw_exp_t;
  sdw_exp_t q[$];
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic run = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [4:0] pos = 5'h0;
  logic [31:0] rdat;
  logic ack, inv, stf, dual, cap, busy, seen;
  logic [7:0] crs, fin, v, f;
  logic [3:0] sl;
  logic [3:0] cs[3] = '{4'h0, 4'h9, 4'hf};
  logic [23:0] tap, fl;
  int fail_count = 0;
  int tests_run = 0;
  int p;
  initial forever #5 clk = ~clk;
  sdw_delay_ctrl #(.RAMP_WINDOW(RW)) i_sdw_delay_ctrl (.clk_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .sysref_tap_i(tap),
    .clock_invert_half_period_o(inv), .coarse_delay_code_o(crs), .fine_delay_code_o(fin),
    .position_step_fine_o(stf), .sysref_sel_o(sl), .dual_edge_sample_o(dual),
    .sysref_capture_o(cap), .ramp_busy_o(busy));
  sdw_sysref_gen i_sdw_sysref_gen (.clk_i(clk), .run_i(run), .pos_i(pos), .sysref_tap_o(tap));
  // ---------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wbc(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 64);
    if (n == 64)
      chk("ack", 1, 0);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(string n, logic [7:0] a, logic [31:0] e, logic [31:0] m);
    q.push_back('{n, e, m});
    wbc(1'b0, a, 32'h0);
  endtask
  // Read data is compared when it appears, against the oldest expectation.
  always @(posedge clk)
  begin
    sdw_exp_t e;
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0)
    begin
      e = q.pop_front();
      chk(e.n, e.v, rdat & e.m);
    end
  end
  task automatic ramp(logic [7:0] c, logic [7:0] t1, int w, logic [7:0] t2, int per, int s);
    int n;
    n = 0;
    wbc(1'b1, 8'ha0, {24'h0, c});
    wbc(1'b1, 8'ha4, {24'h0, t1});
    repeat (w) @(posedge clk);
    wbc(1'b1, 8'ha4, {24'h0, t2});
    chk("busy", 1, busy);
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((busy === 1'b1 || n < 4) && n < 4000);
    @(posedge clk);
    chk("ramp end", t2, crs);
    chk("ramp time", 1, n >= (s - 1) * per && n <= s * per + 8);
    $display("test ramp to %h done", t2);
  endtask
  // The whole run is under a thousand cycles, so this only catches a hang.
  initial
  begin
    #50us;
    fail_count++;
    give_verdict;
  end
  initial
  begin
    p = $urandom(37395);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("ctrl", 8'ha0, 32'h0, 32'h1f);
    rd("coarse", 8'ha4, 32'h0, 32'hff);
    rd("capsel", 8'hbc, 32'h0, 32'hf);
    wbc(1'b1, 8'hb0, 32'h0);
    rd("flags", 8'hb0, 32'hff, 32'hff);
    rd("valid", 8'hac, 32'h0, 32'h1);
    rd("unmapped", 8'h10, 32'h0, 32'hffffffff);
    $display("test reset done");
    repeat (4)
    begin
      v = 8'($urandom) & 8'h1d;
      f = 8'($urandom);
      wbc(1'b1, 8'ha8, {24'h0, f});
      wbc(1'b1, 8'ha0, {24'h0, v});
      repeat (2) @(posedge clk);
      chk("invert", v[0], inv);
      chk("step", v[3], stf);
      chk("dual", v[4], dual);
      chk("fine", f, fin);
      rd("ctrl", 8'ha0, {24'h0, v}, 32'h1f);
    end
    $display("test control done");
    wbc(1'b1, 8'ha0, 32'h0);
    wbc(1'b1, 8'ha4, 32'h40);
    repeat (2) @(posedge clk);
    chk("coarse", 8'h40, crs);
    rd("active", 8'hac, 32'h4000, 32'hff02);
    ramp(8'h02, 8'h43, 0, 8'h43, RW, 3);
    ramp(8'h06, 8'h3d, 0, 8'h3d, RW / 4, 6);
    ramp(8'h06, 8'h45, 9, 8'h3b, RW / 4, 4);
    p = $urandom_range(21, 2);
    fl = 24'h800001 | (24'h3 << (p - 1));
    wbc(1'b1, 8'ha0, 32'h8); // fine steps
    pos <= 5'(p);
    run <= 1'b1;
    repeat (70) @(posedge clk);
    rd("early", 8'hac, 32'h0, 32'h1);
    repeat (100) @(posedge clk);
    rd("valid", 8'hac, 32'h1, 32'h1);
    rd("flags lo", 8'hb0, {24'h0, fl[7:0]}, 32'hff);
    rd("flags mid", 8'hb4, {24'h0, fl[15:8]}, 32'hff);
    rd("flags hi", 8'hb8, {24'h0, fl[23:16]}, 32'hff);
    foreach (cs[k])
    begin
      wbc(1'b1, 8'hbc, {28'h0, cs[k]}); // zero among picks
      repeat (10) @(posedge clk);
      seen = 1'b0;
      repeat (30)
      begin
        @(posedge clk);
        seen |= cap;
      end
      chk("select", cs[k], sl);
      chk("capture", cs[k] < p, seen);
    end
    wbc(1'b1, 8'hbc, (p - 1) / 2); // middle of window
    repeat (2) @(posedge clk);
    chk("midpoint", (p - 1) / 2, sl);
    wbc(1'b1, 8'hbc, 32'hff);
    rd("capsel", 8'hbc, 32'hf, 32'hff);
    wbc(1'b1, 8'ha0, 32'h0);
    repeat (2) @(posedge clk);
    rd("valid", 8'hac, 32'h0, 32'h1);
    rd("flags lo", 8'hb0, 32'hff, 32'hff);
    $display("test detector done");
    chk("queue", 0, q.size());
    give_verdict;
  end
endmodule
